// ==== hw/lpm_pkg.sv ====
// Shared types and constants of the line performance monitor.
// Assumes one system clock and a one-second tick made on that clock.
package lpm_pkg;

    localparam int          LPM_INTERVAL_MIN  = 15;
    localparam int          LPM_SEC_PER_MIN   = 60;
    localparam int          LPM_HISTORY_HOURS = 24;
    localparam int          LPM_MIN_PER_HOUR  = 60;
    localparam logic [9:0]  LPM_SECS_PER_IVL  =
        10'(LPM_INTERVAL_MIN * LPM_SEC_PER_MIN);
    localparam logic [6:0]  LPM_HIST_DEPTH    =
        7'(LPM_HISTORY_HOURS * LPM_MIN_PER_HOUR / LPM_INTERVAL_MIN);

    // Second classification thresholds
    localparam logic [5:0]  LPM_LOOP_SES_CRC  = 6'h32;   // 50
    localparam logic [10:0] LPM_LINE_SES_CODE = 11'h608;  // 1544
    // Unavailable entry after more than this many SES, exit after this
    // many clean seconds
    localparam logic [3:0]  LPM_UAS_ENTER_RUN = 4'hA;
    localparam logic [3:0]  LPM_UAS_EXIT_RUN  = 4'hA;

    typedef struct packed {
        logic frame_check_error;
        logic sync_word_loss;
        logic bipolar_violation;
        logic excess_zero_event;
        logic zero_substitution;
        logic loss_of_signal;
    } lpm_evt_t;

    typedef struct packed {
        logic        valid;
        logic [9:0]  loop_errored_seconds;
        logic [9:0]  loop_severe_error_seconds;
        logic [9:0]  loop_unavailable_seconds;
        logic [9:0]  line_errored_seconds;
        logic [9:0]  line_severe_error_seconds;
        logic [9:0]  line_unavailable_seconds;
        logic [9:0]  density_violation_seconds;
        logic [9:0]  zero_substitution_seconds;
        logic [31:0] line_code_violation_count;
    } lpm_rec_t;

endpackage : lpm_pkg

// ==== hw/lpm_avail.sv ====
// Availability tracker for one monitored loop or line.
// Assumes tick is a one-cycle pulse closing each second, ses valid with it.
`timescale 1ns/1ns
`default_nettype none
module lpm_avail
    import lpm_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic tick,
    input  wire logic ses,
    output var  logic unavail_sec,
    output var  logic in_uas
);
    typedef enum logic {ST_AVAIL, ST_UNAVAIL} lpm_av_state_t;

    lpm_av_state_t state_r;
    logic [3:0]    ses_run_r;
    logic [3:0]    clean_run_r;

    wire enter_w = (state_r == ST_AVAIL) && ses
                   && (ses_run_r == LPM_UAS_ENTER_RUN);
    wire leave_w = (state_r == ST_UNAVAIL) && !ses
                   && (clean_run_r == LPM_UAS_EXIT_RUN - 4'h1);

    // The eleventh SES is the first one counted unavailable
    assign unavail_sec = tick && ((state_r == ST_UNAVAIL) || enter_w);
    assign in_uas      = (state_r == ST_UNAVAIL);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_AVAIL;
            ses_run_r   <= 4'h0;
            clean_run_r <= 4'h0;
        end else if (tick) begin
            case (state_r)
                ST_AVAIL: begin
                    clean_run_r <= 4'h0;
                    if (enter_w) begin
                        state_r   <= ST_UNAVAIL;
                        ses_run_r <= 4'h0;
                    end else begin
                        ses_run_r <= ses ? ses_run_r + 4'h1 : 4'h0;
                    end
                end
                ST_UNAVAIL: begin
                    ses_run_r <= 4'h0;
                    if (leave_w) begin
                        state_r     <= ST_AVAIL;
                        clean_run_r <= 4'h0;
                    end else begin
                        clean_run_r <= ses ? 4'h0 : clean_run_r + 4'h1;
                    end
                end
                default: state_r <= ST_AVAIL;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_uas_enter;
        tick && ses && !in_uas && ses_run_r == 4'hA |=> in_uas;
    endproperty
    a_uas_enter: assert property (p_uas_enter)
        else $error("unavailable state not entered after 11 SES");

    property p_uas_not_early;
        tick && !in_uas && ses_run_r < 4'hA |=> !in_uas;
    endproperty
    a_uas_not_early: assert property (p_uas_not_early)
        else $error("unavailable state entered too early");

    property p_uas_leave;
        tick && !ses && in_uas && clean_run_r == 4'h9 |=> !in_uas;
    endproperty
    a_uas_leave: assert property (p_uas_leave)
        else $error("unavailable state not left after 10 clean seconds");

    c_uas_enter: cover property (tick && enter_w);
    c_uas_leave: cover property (tick && leave_w);

endmodule : lpm_avail
`default_nettype wire

// ==== hw/lpm_monitor.sv ====
// Line performance monitor: second classification, 15-minute intervals
// and a 24-hour interval history.
// Assumes error events and the second tick are one-cycle pulses made on
// clk_sys by the upstream framer; loss_of_signal may be a level.
`timescale 1ns/1ns
`default_nettype none
module lpm_monitor
    import lpm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       sec_tick,
    input  wire lpm_evt_t   evt,
    input  wire logic       data_reset,
    input  wire logic       time_changed,
    input  wire logic [6:0] hist_rd_idx,
    output var  lpm_rec_t   cur_rec,
    output var  lpm_rec_t   prev_rec,
    output var  lpm_rec_t   hist_rec,
    output var  logic [6:0] hist_count,
    output var  logic       interval_done,
    output var  logic       loop_unavail,
    output var  logic       line_unavail
);
    // Per-second accumulators, saturating at the severe thresholds
    logic [5:0]  crc_cnt_r;
    logic        syncloss_r;
    logic [10:0] code_cnt_r;
    logic        los_r;
    logic        zero_run_r;
    logic        zsub_r;
    logic [9:0]  sec_cnt_r;
    logic [6:0]  wp_r;
    lpm_rec_t    cur_r;
    lpm_rec_t    prev_r;
    lpm_rec_t    hist_r;
    logic [6:0]  count_r;
    logic        done_r;
    lpm_rec_t    hist_mem [LPM_HIST_DEPTH];

    // Events in the tick cycle already belong to the next second
    wire  [5:0]  crc_base  = sec_tick ? 6'h00 : crc_cnt_r;
    wire  [10:0] code_base = sec_tick ? 11'h000 : code_cnt_r;
    wire  [6:0]  crc_sum   = {1'b0, crc_base}
                             + 7'(evt.frame_check_error);
    wire  [11:0] code_sum  = {1'b0, code_base}
                             + 12'(evt.bipolar_violation)
                             + 12'(evt.excess_zero_event);
    wire  [5:0]  crc_nxt   = (crc_sum >= 7'(LPM_LOOP_SES_CRC))
                             ? LPM_LOOP_SES_CRC : crc_sum[5:0];
    wire  [10:0] code_nxt  = (code_sum >= 12'(LPM_LINE_SES_CODE))
                             ? LPM_LINE_SES_CODE : code_sum[10:0];

    wire loop_es  = (crc_cnt_r != 6'h00) || syncloss_r;
    wire loop_ses = (crc_cnt_r >= LPM_LOOP_SES_CRC) || syncloss_r;
    wire line_es  = (code_cnt_r != 11'h000) || los_r;
    wire line_ses = (code_cnt_r >= LPM_LINE_SES_CODE) || los_r;
    wire loop_uas_w;
    wire line_uas_w;
    wire loop_in_uas;
    wire line_in_uas;

    lpm_avail u_loop_avail (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .tick        (sec_tick),
        .ses         (loop_ses),
        .unavail_sec (loop_uas_w),
        .in_uas      (loop_in_uas)
    );

    lpm_avail u_line_avail (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .tick        (sec_tick),
        .ses         (line_ses),
        .unavail_sec (line_uas_w),
        .in_uas      (line_in_uas)
    );

    wire closing = sec_tick && (sec_cnt_r == LPM_SECS_PER_IVL - 10'h001);
    wire t       = sec_tick;

    // Current record with this cycle's second and violations folded in
    lpm_rec_t sec_rec;
    always_comb begin
        sec_rec = cur_r;
        sec_rec.loop_errored_seconds      = cur_r.loop_errored_seconds
                                            + 10'(t && loop_es);
        sec_rec.loop_severe_error_seconds = cur_r.loop_severe_error_seconds
                                            + 10'(t && loop_ses);
        sec_rec.loop_unavailable_seconds  = cur_r.loop_unavailable_seconds
                                            + 10'(loop_uas_w);
        sec_rec.line_errored_seconds      = cur_r.line_errored_seconds
                                            + 10'(t && line_es);
        sec_rec.line_severe_error_seconds = cur_r.line_severe_error_seconds
                                            + 10'(t && line_ses);
        sec_rec.line_unavailable_seconds  = cur_r.line_unavailable_seconds
                                            + 10'(line_uas_w);
        sec_rec.density_violation_seconds = cur_r.density_violation_seconds
                                            + 10'(t && zero_run_r);
        sec_rec.zero_substitution_seconds = cur_r.zero_substitution_seconds
                                            + 10'(t && zsub_r);
        sec_rec.line_code_violation_count = cur_r.line_code_violation_count
            + 32'(evt.bipolar_violation)
            + 32'(evt.excess_zero_event);
        if (time_changed) begin
            sec_rec.valid = 1'b0;
        end
    end

    // Fresh interval is valid unless invalidated in its first cycle
    lpm_rec_t fresh_rec;
    always_comb begin
        fresh_rec       = '0;
        fresh_rec.valid = !time_changed;
    end

    // History read, entry 0 is the newest
    wire [7:0] rd_sum  = 8'(wp_r) + 8'(LPM_HIST_DEPTH) - 8'h01
                         - 8'(hist_rd_idx);
    wire [6:0] rd_addr = (rd_sum >= 8'(LPM_HIST_DEPTH))
                         ? 7'(rd_sum - 8'(LPM_HIST_DEPTH)) : rd_sum[6:0];
    wire       rd_ok   = hist_rd_idx < count_r;
    wire [6:0] wp_nxt  = (wp_r == LPM_HIST_DEPTH - 7'h01)
                         ? 7'h00 : wp_r + 7'h01;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            crc_cnt_r  <= 6'h00;
            syncloss_r <= 1'b0;
            code_cnt_r <= 11'h000;
            los_r      <= 1'b0;
            zero_run_r <= 1'b0;
            zsub_r     <= 1'b0;
        end else begin
            crc_cnt_r  <= crc_nxt;
            code_cnt_r <= code_nxt;
            syncloss_r <= (syncloss_r && !t) || evt.sync_word_loss;
            los_r      <= (los_r && !t) || evt.loss_of_signal;
            zero_run_r <= (zero_run_r && !t) || evt.excess_zero_event;
            zsub_r     <= (zsub_r && !t) || evt.zero_substitution;
        end
    end

    // Reset leaves the first interval invalid as a restart mark
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_r     <= '0;
            prev_r    <= '0;
            sec_cnt_r <= 10'h000;
            wp_r      <= 7'h00;
            count_r   <= 7'h00;
            done_r    <= 1'b0;
        end else if (data_reset) begin
            cur_r     <= '0;
            prev_r    <= '0;
            wp_r      <= 7'h00;
            count_r   <= 7'h00;
            done_r    <= 1'b0;
            sec_cnt_r <= closing ? 10'h000 : sec_cnt_r + 10'(t);
        end else if (closing) begin
            prev_r    <= sec_rec;
            cur_r     <= fresh_rec;
            sec_cnt_r <= 10'h000;
            wp_r      <= wp_nxt;
            count_r   <= (count_r == LPM_HIST_DEPTH)
                         ? count_r : count_r + 7'h01;
            done_r    <= 1'b1;
        end else begin
            cur_r     <= sec_rec;
            sec_cnt_r <= sec_cnt_r + 10'(t);
            done_r    <= 1'b0;
        end
    end

    // Oldest entry is overwritten once the ring is full
    always_ff @(posedge clk_sys) begin
        if (closing && !data_reset) begin
            hist_mem[wp_r] <= sec_rec;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hist_r <= '0;
        end else begin
            hist_r <= rd_ok ? hist_mem[rd_addr] : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            loop_unavail <= 1'b0;
            line_unavail <= 1'b0;
        end else begin
            loop_unavail <= loop_in_uas;
            line_unavail <= line_in_uas;
        end
    end

    assign cur_rec       = cur_r;
    assign prev_rec      = prev_r;
    assign hist_rec      = hist_r;
    assign hist_count    = count_r;
    assign interval_done = done_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    wire plain = !closing && !data_reset;

    property p_interval_move;
        closing && !data_reset |=> prev_r == $past(sec_rec)
            && cur_r.line_code_violation_count == 32'h0 && done_r;
    endproperty
    a_interval_move: assert property (p_interval_move)
        else $error("interval not moved to previous register");

    property p_hist_ring;
        closing && !data_reset |=> wp_r == $past(wp_nxt)
            && count_r <= LPM_HIST_DEPTH && count_r != 7'h00;
    endproperty
    a_hist_ring: assert property (p_hist_ring)
        else $error("history ring not advanced");

    property p_loop_es;
        t && plain && loop_es |=> cur_r.loop_errored_seconds
            == $past(cur_r.loop_errored_seconds) + 10'h001;
    endproperty
    a_loop_es: assert property (p_loop_es)
        else $error("loop errored second not counted");

    property p_loop_ses;
        t && plain |=> cur_r.loop_severe_error_seconds
            == $past(cur_r.loop_severe_error_seconds)
            + 10'($past(crc_cnt_r) >= 6'h32 || $past(syncloss_r));
    endproperty
    a_loop_ses: assert property (p_loop_ses)
        else $error("loop severe second miscounted");

    property p_line_es;
        t && plain |=> cur_r.line_errored_seconds
            == $past(cur_r.line_errored_seconds)
            + 10'($past(code_cnt_r) != 11'h0 || $past(los_r));
    endproperty
    a_line_es: assert property (p_line_es)
        else $error("line errored second miscounted");

    property p_line_ses;
        t && plain |=> cur_r.line_severe_error_seconds
            == $past(cur_r.line_severe_error_seconds)
            + 10'($past(code_cnt_r) >= 11'h608 || $past(los_r));
    endproperty
    a_line_ses: assert property (p_line_ses)
        else $error("line severe second miscounted");

    property p_pdvs;
        evt.excess_zero_event && !t ##1 t && plain |=>
            cur_r.density_violation_seconds
            == $past(cur_r.density_violation_seconds) + 10'h001;
    endproperty
    a_pdvs: assert property (p_pdvs)
        else $error("density violation second not counted");

    property p_zss;
        evt.zero_substitution && !t ##1 t && plain |=>
            cur_r.zero_substitution_seconds
            == $past(cur_r.zero_substitution_seconds) + 10'h001;
    endproperty
    a_zss: assert property (p_zss)
        else $error("substitution second not counted");

    property p_cv;
        plain |=> cur_r.line_code_violation_count
            == $past(cur_r.line_code_violation_count)
            + 32'($past(evt.bipolar_violation))
            + 32'($past(evt.excess_zero_event));
    endproperty
    a_cv: assert property (p_cv)
        else $error("code violation count wrong");

    property p_invalid;
        (time_changed || data_reset) |=> !cur_r.valid;
    endproperty
    a_invalid: assert property (p_invalid)
        else $error("interval not marked invalid");

    property p_sec_clear;
        t |=> crc_cnt_r == 6'($past(evt.frame_check_error));
    endproperty
    a_sec_clear: assert property (p_sec_clear)
        else $error("per-second count not cleared on tick");

    c_interval: cover property (closing && !data_reset);
    c_hist_full: cover property (count_r == LPM_HIST_DEPTH && closing);
    c_time_chg: cover property (time_changed && t);

endmodule : lpm_monitor
`default_nettype wire

// ==== verif/lpm_framer_model.sv ====
// Stand-in for the upstream framer: error event pulses and the second tick.
// Assumes callers resume just after a rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module lpm_framer_model
    import lpm_pkg::*;
(
    input  wire logic     clk_sys,
    output var  lpm_evt_t evt,
    output var  logic     sec_tick
);
    initial begin
        evt      = '0;
        sec_tick = 1'b0;
    end

    // Events back to back, then a clean tick cycle so nothing spills over
    task automatic send(input int crc, sync, bipol, xzero, zs, input bit los);
        int n;
        n = (crc > bipol) ? crc : bipol;
        n = (sync > n) ? sync : n;
        n = (xzero > n) ? xzero : n;
        n = (zs > n) ? zs : n;
        n = (n < 1) ? 1 : n;
        for (int i = 0; i < n; i++) begin
            evt.frame_check_error = (i < crc);
            evt.sync_word_loss    = (i < sync);
            evt.bipolar_violation = (i < bipol);
            evt.excess_zero_event = (i < xzero);
            evt.zero_substitution = (i < zs);
            evt.loss_of_signal    = los;
            @(posedge clk_sys);
            #1;
        end
        evt      = '0;
        sec_tick = 1'b1;
        @(posedge clk_sys);
        #1;
        sec_tick = 1'b0;
    endtask : send

    // Quiet seconds, one tick per cycle, to reach interval ends quickly
    task automatic ticks(input int k);
        @(posedge clk_sys);
        #1;
        sec_tick = 1'b1;
        repeat (k) @(posedge clk_sys);
        #1;
        sec_tick = 1'b0;
    endtask : ticks
endmodule : lpm_framer_model
`default_nettype wire

// ==== verif/test_line_performance_monitor.sv ====
// Self-checking bench of the line performance monitor.
// Assumes lpm_framer_model supplies the error events and the second tick.
`timescale 1ns/1ns
`default_nettype none
module test_line_performance_monitor
    import lpm_pkg::*;
;
    logic       clk_sys;
    logic       resetn;
    logic       data_reset;
    logic       time_changed;
    logic [6:0] hist_rd_idx;
    logic       sec_tick;
    lpm_evt_t   evt;
    lpm_rec_t   cur_rec;
    lpm_rec_t   prev_rec;
    lpm_rec_t   hist_rec;
    logic [6:0] hist_count;
    logic       interval_done;
    logic       loop_unavail;
    logic       line_unavail;
    int         fails    = 0;
    int         compares = 0;
    int         nticks   = 0;
    int         cyc      = 0;
    lpm_rec_t   exp_cur;
    lpm_rec_t   exp_prev;
    lpm_rec_t   hq[$];
    int         run[2];
    int         clean[2];
    bit         st[2];

    lpm_framer_model fr (
        .clk_sys  (clk_sys),
        .evt      (evt),
        .sec_tick (sec_tick)
    );

    lpm_monitor dut (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .sec_tick      (sec_tick),
        .evt           (evt),
        .data_reset    (data_reset),
        .time_changed  (time_changed),
        .hist_rd_idx   (hist_rd_idx),
        .cur_rec       (cur_rec),
        .prev_rec      (prev_rec),
        .hist_rec      (hist_rec),
        .hist_count    (hist_count),
        .interval_done (interval_done),
        .loop_unavail  (loop_unavail),
        .line_unavail  (line_unavail)
    );

    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic chk_rec(input string nm, input lpm_rec_t e,
                           input lpm_rec_t g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_rec

    task automatic chk_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk_val

    // Returns whether this second counts unavailable; k 0 loop, 1 line
    function automatic bit uas_step(input bit ses, input int k);
        bit u;
        if (!st[k]) begin
            run[k] = ses ? run[k] + 1 : 0;
            if (run[k] > 10) begin
                st[k]    = 1'b1;
                clean[k] = 0;
            end
        end else if (ses) begin
            clean[k] = 0;
        end else begin
            clean[k]++;
        end
        u = st[k];
        if (st[k] && clean[k] == 10) begin
            st[k]  = 1'b0;
            run[k] = 0;
        end
        return u;
    endfunction : uas_step

    function automatic void model_sec(input int crc, sync, bipol, xzero, zs,
                                      input bit los);
        bit lses;
        bit nses;
        lses = (crc >= 50) || (sync >= 1);
        nses = (bipol + xzero >= 1544) || los;
        exp_cur.loop_errored_seconds += 10'((crc >= 1) || (sync >= 1));
        exp_cur.loop_severe_error_seconds += 10'(lses);
        exp_cur.line_errored_seconds += 10'((bipol + xzero >= 1) || los);
        exp_cur.line_severe_error_seconds += 10'(nses);
        exp_cur.loop_unavailable_seconds += 10'(uas_step(lses, 0));
        exp_cur.line_unavailable_seconds += 10'(uas_step(nses, 1));
        exp_cur.density_violation_seconds += 10'(xzero >= 1);
        exp_cur.zero_substitution_seconds += 10'(zs >= 1);
        exp_cur.line_code_violation_count += 32'(bipol + xzero);
    endfunction : model_sec

    task automatic close_ivl();
        exp_prev = exp_cur;
        hq.push_front(exp_cur);
        if (hq.size() > int'(LPM_HIST_DEPTH))
            hq.pop_back();
        exp_cur       = '0;
        exp_cur.valid = 1'b1;
        chk_val("interval_done", 1, interval_done);
        chk_rec("prev_rec", exp_prev, prev_rec);
        chk_rec("cur_rec", exp_cur, cur_rec);
        chk_val("hist_count", 32'(hq.size()), 32'(hist_count));
        repeat (2) @(posedge clk_sys);
        #1;
        chk_rec("hist_rec", exp_prev, hist_rec);
    endtask : close_ivl

    task automatic second(input int crc, sync, bipol, xzero, zs,
                          input bit los);
        fr.send(crc, sync, bipol, xzero, zs, los);
        model_sec(crc, sync, bipol, xzero, zs, los);
        nticks++;
        chk_val("interval_done", 0, interval_done);
        chk_rec("cur_rec", exp_cur, cur_rec);
        @(posedge clk_sys);
        #1;
        chk_val("loop_unavail", 32'(st[0]), 32'(loop_unavail));
        chk_val("line_unavail", 32'(st[1]), 32'(line_unavail));
    endtask : second

    // Quiet seconds up to the next interval end
    task automatic fill();
        int k;
        k = int'(LPM_SECS_PER_IVL) - nticks % int'(LPM_SECS_PER_IVL);
        fr.ticks(k);
        nticks += k;
        run[0] = 0;
        run[1] = 0;
        close_ivl();
    endtask : fill

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 98000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        int       r;
        lpm_rec_t e;
        resetn       = 1'b0;
        data_reset   = 1'b0;
        time_changed = 1'b0;
        hist_rd_idx  = 7'h00;
        exp_cur      = '0;
        r = $urandom(32'h38BD8910);
        repeat (8) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        chk_rec("cur_rec", exp_cur, cur_rec);
        chk_val("hist_count", 0, 32'(hist_count));
        second(1, 0, 0, 0, 0, 0);
        second(49, 0, 0, 0, 0, 0);
        second(50, 0, 0, 0, 0, 0);
        second(0, 1, 0, 0, 0, 0);
        second(0, 0, 1, 0, 0, 0);
        second(0, 0, 0, 1, 0, 0);
        second(0, 0, 3, 3, 0, 0);
        second(0, 0, 1000, 543, 0, 0);
        second(0, 0, 1544, 0, 0, 0);
        second(0, 0, 0, 0, 0, 1);
        second(0, 0, 0, 0, 1, 0);
        repeat (20) second($urandom % 60, $urandom % 8 == 0, $urandom % 40,
                           $urandom % 3, $urandom % 2, $urandom % 16 == 0);
        repeat (11) second(0, 1, 0, 0, 0, 1);
        repeat (11) second(0, 0, 0, 0, 0, 0);
        fill();
        time_changed = 1'b1;
        @(posedge clk_sys);
        #1;
        time_changed  = 1'b0;
        exp_cur.valid = 1'b0;
        chk_rec("cur_rec", exp_cur, cur_rec);
        fill();
        data_reset = 1'b1;
        @(posedge clk_sys);
        #1;
        data_reset = 1'b0;
        exp_cur    = '0;
        exp_prev   = '0;
        hq.delete();
        chk_rec("cur_rec", exp_cur, cur_rec);
        chk_rec("prev_rec", exp_prev, prev_rec);
        chk_val("hist_count", 0, 32'(hist_count));
        repeat (97) fill();
        for (int i = 94; i < 97; i++) begin
            e           = (i < hq.size()) ? hq[i] : lpm_rec_t'('0);
            hist_rd_idx = 7'(i);
            repeat (2) @(posedge clk_sys);
            #1;
            chk_rec("hist_rec", e, hist_rec);
        end
        final_report();
    end
endmodule : test_line_performance_monitor
`default_nettype wire
